// >>> hdl/asq_cmd_if.sv
// Carrier for the command word passed from the link domain to the core.
`timescale 1ns/10ps
`default_nettype none
interface asq_cmd_if;
	logic [15:0] word;
	logic tgl;
	modport link (output word, output tgl);
	modport core (input word, input tgl);
endinterface : asq_cmd_if
`default_nettype wire

// >>> hdl/asq_defs.svh
// Constants for the scan-mode decoder and channel sequencer.
`ifndef ASQ_DEFS_SVH
`define ASQ_DEFS_SVH

// ----------------------------------------------------------------------------
// Scan codes
// ----------------------------------------------------------------------------
`define ASQ_CODE_KEEP 4'h0
`define ASQ_CODE_STD_INT 4'h3
`define ASQ_CODE_STD_EXT 4'h4
`define ASQ_CODE_UPPER_INT 4'h5
`define ASQ_CODE_UPPER_EXT 4'h6
`define ASQ_CODE_CUSTOM_INT 4'h7
`define ASQ_CODE_CUSTOM_EXT 4'h8
`define ASQ_CODE_SEQ_SET 4'h9
`define ASQ_CODE_RST 4'h4

// ----------------------------------------------------------------------------
// Command word layout
// ----------------------------------------------------------------------------
`define ASQ_WORD_SEL_BIT 15
`define ASQ_SCAN_MSB 14
`define ASQ_SCAN_LSB 11
`define ASQ_CHSEL_MSB 10
`define ASQ_CHSEL_LSB 7
`define ASQ_FRAME_BITS 5'h10

// ----------------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------------
`define ASQ_REG_CTRL 4'h0
`define ASQ_REG_CUSTOM 4'h1
`define ASQ_REG_SEQ_LEN 4'h2
`define ASQ_REG_SEQ_ADDR 4'h3
`define ASQ_REG_SEQ_DATA 4'h4
`define ASQ_REG_STATUS 4'h5
`define ASQ_REG_RESULTS 4'h6
`define ASQ_CTRL_START_BIT 0
`define ASQ_CUSTOM_RST 16'h0000
`define ASQ_SEQ_LEN_RST 8'h00
`define ASQ_CHSEL_RST 4'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define ASQ_REF_CLK_MHZ 40
`define ASQ_INT_CONV_NS 1000
`define ASQ_INT_CONV_CYCLES ((`ASQ_INT_CONV_NS * `ASQ_REF_CLK_MHZ + 999) / 1000)

`endif

// >>> hdl/asq_link_rx.sv
// Serial frame receiver running on the link clock.
`timescale 1ns/10ps
`default_nettype none
`include "asq_defs.svh"
module asq_link_rx (
	input wire logic link_sclk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic din,
	asq_cmd_if.link cmd
);
	logic [4:0] bit_cnt_q;
	logic [15:0] shift_q;
	logic [15:0] word_q;
	logic tgl_q;

	// Bit counter; the frame select clears it since the clock stops between frames.
	always_ff @(posedge link_sclk or posedge rst or posedge cs_n) begin
		if (rst) begin
			bit_cnt_q <= 5'h00;
		end else if (cs_n) begin
			bit_cnt_q <= 5'h00;
		end else if (bit_cnt_q != `ASQ_FRAME_BITS) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	// Shift register, most significant bit first.
	always_ff @(posedge link_sclk or posedge rst) begin
		if (rst) begin
			shift_q <= 16'h0000;
		end else if (!cs_n) begin
			shift_q <= {shift_q[14:0], din};
		end
	end

	// The word is held and a toggle flips when the sixteenth bit arrives.
	always_ff @(posedge link_sclk or posedge rst) begin
		if (rst) begin
			word_q <= 16'h0000;
			tgl_q <= 1'b0;
		end else if (!cs_n && bit_cnt_q == `ASQ_FRAME_BITS - 5'h01) begin
			word_q <= {shift_q[14:0], din};
			tgl_q <= ~tgl_q;
		end
	end

	assign cmd.word = word_q;
	assign cmd.tgl = tgl_q;
endmodule : asq_link_rx
`default_nettype wire

// >>> hdl/asq_pkg.sv
// Types shared by the scan-mode sequencer modules.
package asq_pkg;
	typedef logic [3:0] asq_chan_t;
	typedef logic [3:0] asq_scan_t;
	typedef enum logic {ST_IDLE, ST_RUN} asq_state_t;
endpackage : asq_pkg

// >>> hdl/asq_scan_sequencer.sv
// Scan-mode decoder and channel sequencer top level.
// Operation
// - Standard external: channels zero to N ascending.
// - Upper internal: N to highest, internal clock.
// - Upper internal result count is channels minus N.
// - Custom internal: programmed set, up to sixteen results.
// - Custom external: programmed set, host paced.
// - Custom modes visit each channel once, ascending.
// - Custom membership comes from custom set register.
// - Sequence mode steps list of up to 256 entries.
// - Sequence mode paced only by host frames.
// - Codes 1010 to 1111 keep mode, ignore rest.
// - Channel select is plain unsigned channel index.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "asq_defs.svh"
module asq_scan_sequencer #(
	parameter int CHANNELS = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic link_sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic conv_start,
	output logic [3:0] conv_channel,
	output logic conv_int_clk,
	output logic conv_avg_allowed,
	output logic [8:0] result_count,
	output logic seq_busy
);
	localparam int CONV_CYC = `ASQ_INT_CONV_CYCLES;
	localparam logic [3:0] TOP_CH = 4'(CHANNELS - 1);

	// ------------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------------

	// Lowest set channel at or above a start point; bit 4 flags a hit.
	function automatic logic [4:0] first_from(input logic [15:0] mask, input logic [4:0] from);
		logic [4:0] res;
		res = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (mask[i] && 5'(i) >= from) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction : first_from

	// Mask with every channel from lo to hi set.
	function automatic logic [15:0] range_mask(input logic [3:0] lo, input logic [3:0] hi);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			m[i] = (4'(i) >= lo) && (4'(i) <= hi);
		end
		return m;
	endfunction : range_mask

	// Number of channels set in a mask.
	function automatic logic [8:0] pop_count(input logic [15:0] mask);
		logic [8:0] n;
		n = 9'h000;
		for (int i = 0; i < 16; i++) begin
			n = n + {8'h00, mask[i]};
		end
		return n;
	endfunction : pop_count

	// Codes that select a mode handled by this block.
	function automatic logic code_ok(input asq_pkg::asq_scan_t c);
		return c >= `ASQ_CODE_STD_INT && c <= `ASQ_CODE_SEQ_SET;
	endfunction : code_ok

	// Modes paced by the internal conversion clock.
	function automatic logic code_int(input asq_pkg::asq_scan_t c);
		return c == `ASQ_CODE_STD_INT || c == `ASQ_CODE_UPPER_INT || c == `ASQ_CODE_CUSTOM_INT;
	endfunction : code_int

	// ------------------------------------------------------------------------
	// Link domain and crossing
	// ------------------------------------------------------------------------
	asq_cmd_if cmd_bus ();

	asq_link_rx u_link_rx (
		.link_sclk(link_sclk),
		.rst(rst),
		.cs_n(cs_n),
		.din(din),
		.cmd(cmd_bus.link)
	);

	logic tgl_s1_q;
	logic tgl_s2_q;
	logic tgl_s3_q;
	logic frame_ev;

	// Toggle synchroniser; the word is stable long before the toggle lands.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else begin
			tgl_s1_q <= cmd_bus.tgl;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	assign frame_ev = tgl_s2_q ^ tgl_s3_q;

	// ------------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------------
	asq_pkg::asq_scan_t scan_q;
	asq_pkg::asq_chan_t chsel_q;
	asq_pkg::asq_scan_t word_code;
	logic restart;
	logic int_mode;
	logic seq_mode;

	assign word_code = cmd_bus.word[`ASQ_SCAN_MSB:`ASQ_SCAN_LSB];
	// Only a mode word carrying a handled code restarts the pass; other frames still step the external modes.
	assign restart = frame_ev && !cmd_bus.word[`ASQ_WORD_SEL_BIT] && code_ok(word_code);
	assign int_mode = code_int(scan_q);
	assign seq_mode = scan_q == `ASQ_CODE_SEQ_SET;

	// Scan code and channel select; unhandled codes leave both untouched.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scan_q <= `ASQ_CODE_RST;
			chsel_q <= `ASQ_CHSEL_RST;
		end else if (restart) begin
			scan_q <= word_code;
			chsel_q <= cmd_bus.word[`ASQ_CHSEL_MSB:`ASQ_CHSEL_LSB];
		end
	end

	// ------------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------------
	logic [15:0] custom_q;
	logic [7:0] seq_len_q;
	logic [7:0] seq_addr_q;
	logic mem_we;
	logic start_req;

	assign mem_we = reg_wr && reg_addr == `ASQ_REG_SEQ_DATA;
	assign start_req = reg_wr && reg_addr == `ASQ_REG_CTRL && reg_wdata[`ASQ_CTRL_START_BIT];

	// Software-written configuration; list writes advance the address.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			custom_q <= `ASQ_CUSTOM_RST;
			seq_len_q <= `ASQ_SEQ_LEN_RST;
			seq_addr_q <= 8'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				`ASQ_REG_CUSTOM: custom_q <= reg_wdata;
				`ASQ_REG_SEQ_LEN: seq_len_q <= reg_wdata[7:0];
				`ASQ_REG_SEQ_ADDR: seq_addr_q <= reg_wdata[7:0];
				`ASQ_REG_SEQ_DATA: seq_addr_q <= seq_addr_q + 8'h01;
				default: seq_len_q <= seq_len_q;
			endcase
		end
	end

	logic [7:0] pos_q;
	logic [3:0] list_ch;

	asq_seq_mem u_seq_mem (
		.clk(ref_clk),
		.we(mem_we),
		.waddr(seq_addr_q),
		.wdata(reg_wdata[3:0]),
		.raddr(pos_q),
		.rdata(list_ch)
	);

	// ------------------------------------------------------------------------
	// Channel membership and result count
	// ------------------------------------------------------------------------
	logic [15:0] act_mask;
	logic [8:0] count_d;

	// Membership of the active pass for every mask-driven mode.
	always_comb begin
		case (scan_q)
			`ASQ_CODE_STD_INT: act_mask = range_mask(4'h0, chsel_q);
			`ASQ_CODE_STD_EXT: act_mask = range_mask(4'h0, chsel_q);
			`ASQ_CODE_UPPER_INT: act_mask = range_mask(chsel_q, TOP_CH);
			`ASQ_CODE_UPPER_EXT: act_mask = range_mask(chsel_q, TOP_CH);
			`ASQ_CODE_CUSTOM_INT: act_mask = custom_q & range_mask(4'h0, TOP_CH);
			`ASQ_CODE_CUSTOM_EXT: act_mask = custom_q & range_mask(4'h0, TOP_CH);
			default: act_mask = 16'h0000;
		endcase
	end

	// Results one pass leaves behind.
	always_comb begin
		case (scan_q)
			`ASQ_CODE_UPPER_INT: count_d = 9'(CHANNELS) - {5'h00, chsel_q};
			`ASQ_CODE_SEQ_SET: count_d = {1'b0, seq_len_q} + 9'h001;
			default: count_d = pop_count(act_mask);
		endcase
	end

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	asq_pkg::asq_state_t state_q;
	logic [4:0] from_q;
	logic [5:0] tmr_q;
	logic int_tick;
	logic ext_step;
	logic step;
	logic [4:0] hit;
	logic [4:0] nxt;

	// External modes advance one conversion per host frame; the list mode only so.
	assign ext_step = frame_ev && !restart && !int_mode;
	assign int_tick = state_q == asq_pkg::ST_RUN && int_mode && tmr_q == 6'(CONV_CYC - 1);
	assign step = ext_step || int_tick || (start_req && int_mode && state_q == asq_pkg::ST_IDLE);
	assign hit = first_from(act_mask, from_q);
	assign nxt = first_from(act_mask, {1'b0, hit[3:0]} + 5'h01);

	// Internal conversion timer.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tmr_q <= 6'h00;
		end else if (step || state_q == asq_pkg::ST_IDLE) begin
			tmr_q <= 6'h00;
		end else begin
			tmr_q <= tmr_q + 6'h01;
		end
	end

	// Pass control: position, next channel, and the conversion strobe.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= asq_pkg::ST_IDLE;
			from_q <= 5'h00;
			pos_q <= 8'h00;
			conv_start <= 1'b0;
			conv_channel <= 4'h0;
		end else begin
			conv_start <= 1'b0;
			if (restart) begin
				state_q <= asq_pkg::ST_IDLE;
				from_q <= 5'h00;
				pos_q <= 8'h00;
			end else if (step) begin
				case (state_q)
					asq_pkg::ST_IDLE, asq_pkg::ST_RUN: begin
						if (seq_mode) begin
							conv_start <= 1'b1;
							conv_channel <= list_ch;
							if (pos_q == seq_len_q) begin
								state_q <= asq_pkg::ST_IDLE;
								pos_q <= 8'h00;
							end else begin
								state_q <= asq_pkg::ST_RUN;
								pos_q <= pos_q + 8'h01;
							end
						end else if (hit[4]) begin
							conv_start <= 1'b1;
							conv_channel <= hit[3:0];
							// Each member once, lowest first, pass ends after the last.
							if (nxt[4]) begin
								state_q <= asq_pkg::ST_RUN;
								from_q <= {1'b0, hit[3:0]} + 5'h01;
							end else begin
								state_q <= asq_pkg::ST_IDLE;
								from_q <= 5'h00;
							end
						end else begin
							state_q <= asq_pkg::ST_IDLE;
							from_q <= 5'h00;
						end
					end
					default: state_q <= asq_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Mode attribute outputs
	// ------------------------------------------------------------------------

	// Clock source, averaging permission, result count and busy flag.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			conv_int_clk <= 1'b0;
			conv_avg_allowed <= 1'b0;
			result_count <= 9'h000;
			seq_busy <= 1'b0;
		end else begin
			conv_int_clk <= int_mode;
			conv_avg_allowed <= int_mode;
			result_count <= count_d;
			seq_busy <= state_q == asq_pkg::ST_RUN;
		end
	end

	// Read data appears in the cycle after the read strobe and only there.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`ASQ_REG_CUSTOM: reg_rdata <= custom_q;
				`ASQ_REG_SEQ_LEN: reg_rdata <= {8'h00, seq_len_q};
				`ASQ_REG_SEQ_ADDR: reg_rdata <= {8'h00, seq_addr_q};
				`ASQ_REG_STATUS: reg_rdata <= {3'h0, state_q == asq_pkg::ST_RUN, scan_q, chsel_q, conv_channel};
				`ASQ_REG_RESULTS: reg_rdata <= {7'h00, count_d};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule : asq_scan_sequencer
`default_nettype wire

// >>> hdl/asq_seq_mem.sv
// Channel list store for the free-form sequence mode.
`timescale 1ns/10ps
`default_nettype none
module asq_seq_mem (
	input wire logic clk,
	input wire logic we,
	input wire logic [7:0] waddr,
	input wire logic [3:0] wdata,
	input wire logic [7:0] raddr,
	output logic [3:0] rdata
);
	logic [3:0] mem [0:255];

	// Write port.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read is combinational so the sequencer sees the entry at its position.
	assign rdata = mem[raddr];
endmodule : asq_seq_mem
`default_nettype wire

// >>> tb/asq_host_model.sv
// Serial host model that sends command frames.
`timescale 1ns/10ps
`default_nettype none
module asq_host_model (
	output logic link_sclk,
	output logic cs_n,
	output logic din
);
	// Idle: clock stopped, frame deselected.
	initial begin
		link_sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	// Sends one 16-bit word, first bit the top one, with a clock edge for every bit.
	task automatic send(input logic [15:0] w);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			din = w[i];
			#6 link_sclk = 1'b1;
			#6 link_sclk = 1'b0;
		end
		#3 cs_n = 1'b1;
		din = ~din;
		#20;
	endtask : send
endmodule : asq_host_model
`default_nettype wire

// >>> tb/asq_scan_sequencer_asserts.sv
// Port checker for the scan-mode sequencer.
`timescale 1ns/10ps
`default_nettype none
module asq_scan_sequencer_asserts #(
	parameter int CHANNELS = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic conv_start,
	input wire logic [3:0] conv_channel,
	input wire logic conv_int_clk,
	input wire logic conv_avg_allowed,
	input wire logic [8:0] result_count,
	input wire logic seq_busy
);
	logic [7:0] gap_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ------
	// Checks
	// ------
	// Counts cycles since the last conversion request.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gap_q <= 8'h00;
		end else if (conv_start) begin
			gap_q <= 8'h00;
		end else if (gap_q != 8'hff) begin
			gap_q <= gap_q + 8'h01;
		end
	end
	property p_avg; conv_avg_allowed == conv_int_clk; endproperty
	a_avg: assert property (p_avg) else $error("averaging flag differs from clock source");
	property p_pace; conv_start && conv_int_clk && $past(seq_busy) |-> gap_q == 8'h27; endproperty
	a_pace: assert property (p_pace) else $error("internal conversions not 40 cycles apart");
	property p_pulse; conv_start |=> !conv_start [*5]; endproperty
	a_pulse: assert property (p_pulse) else $error("conversion requests too close");
	// The registered outputs take their first post-reset values one edge after release.
	property p_rst; $fell(rst) |=> result_count == 9'h001 && !conv_int_clk; endproperty
	a_rst: assert property (p_rst) else $error("wrong state after reset");
	property p_chan; conv_start |-> conv_channel < CHANNELS; endproperty
	a_chan: assert property (p_chan) else $error("channel beyond the part");
	property p_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("read data outside read slot");
	property p_cnt; $past(reg_rd) && $past(reg_addr) == 4'h6 |-> reg_rdata == {7'h00, $past(result_count)}; endproperty
	a_cnt: assert property (p_cnt) else $error("result count read wrong");
	property p_stat; $past(reg_rd) && $past(reg_addr) == 4'h5 |-> reg_rdata[3:0] == $past(conv_channel); endproperty
	a_stat: assert property (p_stat) else $error("status channel wrong");
	property p_unmap; $past(reg_rd) && $past(reg_addr) > 4'h6 |-> reg_rdata == 16'h0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	c_int: cover property (conv_start && conv_int_clk);
	c_ext: cover property (conv_start && !conv_int_clk);
	c_end: cover property ($fell(seq_busy));
endmodule : asq_scan_sequencer_asserts
bind asq_scan_sequencer asq_scan_sequencer_asserts #(.CHANNELS(CHANNELS)) u_chk (.ref_clk(ref_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
	.conv_channel(conv_channel), .conv_int_clk(conv_int_clk), .conv_avg_allowed(conv_avg_allowed),
	.result_count(result_count), .seq_busy(seq_busy));
`default_nettype wire

// >>> tb/test_adc_scan_mode_sequencer.sv
// Self-checking bench of the scan-mode sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "asq_defs.svh"
module test_adc_scan_mode_sequencer;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic link_sclk, cs_n, din;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata, st;
	logic conv_start, conv_int_clk, conv_avg_allowed, seq_busy;
	logic [3:0] conv_channel;
	logic [8:0] result_count;
	logic [3:0] seen[$];
	logic [3:0] exp[$];
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	asq_scan_sequencer #(.CHANNELS(16)) DUT (.ref_clk(ref_clk), .rst(rst), .link_sclk(link_sclk), .cs_n(cs_n),
		.din(din), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .conv_start(conv_start), .conv_channel(conv_channel), .conv_int_clk(conv_int_clk),
		.conv_avg_allowed(conv_avg_allowed), .result_count(result_count), .seq_busy(seq_busy));
	asq_host_model host (.link_sclk(link_sclk), .cs_n(cs_n), .din(din));
	// ------
	// Tasks
	// ------
	// Core clock.
	always #12.5 ref_clk = ~ref_clk;
	// Records each requested channel and cuts a hang short.
	always @(posedge ref_clk) begin
		if (conv_start === 1'b1) begin
			seen.push_back(conv_channel);
		end
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task automatic frame(input logic [15:0] w);
		host.send(w);
		repeat (8) @(posedge ref_clk);
	endtask : frame
	task automatic cmpq();
		chk(16'(seen.size()), 16'(exp.size()));
		foreach (exp[i]) chk({12'h000, seen[i]}, {12'h000, exp[i]});
		seen.delete();
	endtask : cmpq
	task automatic runs(input int k);
		seen.delete();
		for (int i = 0; i < k; i++) frame(16'h8000);
	endtask : runs
	task automatic close_out();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	function automatic logic [15:0] mw(input logic [3:0] c, input logic [3:0] n);
		return {1'b0, c, n, 7'h00};
	endfunction : mw
	// Main sequence.
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rd(`ASQ_REG_STATUS, st);
		chk({8'h00, st[11:4]}, 16'h0040);
		rd(`ASQ_REG_RESULTS, st);
		chk(st, 16'h0001);
		rd(4'hf, st);
		chk(st, 16'h0000);
		for (int n = 0; n < 16; n++) begin
			frame(mw(`ASQ_CODE_STD_EXT, 4'(n)));
			rd(`ASQ_REG_STATUS, st);
			chk({12'h000, st[7:4]}, 16'(n));
			rd(`ASQ_REG_RESULTS, st);
			chk(st, 16'(n + 1));
		end
		frame(mw(`ASQ_CODE_STD_EXT, 4'h3));
		runs(5);
		exp = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0};
		cmpq();
		chk({15'h0000, seq_busy}, 16'h0001);
		chk({15'h0000, conv_avg_allowed}, 16'h0000);
		for (int c = 10; c < 16; c++) begin
			frame({1'b0, 4'(c), 11'h7ff});
			rd(`ASQ_REG_STATUS, st);
			chk({8'h00, st[11:4]}, 16'h0043);
		end
		frame(mw(`ASQ_CODE_UPPER_EXT, 4'hd));
		runs(4);
		exp = '{4'hd, 4'he, 4'hf, 4'hd};
		cmpq();
		chk({15'h0000, conv_int_clk}, 16'h0000);
		chk({15'h0000, conv_avg_allowed}, 16'h0000);
		frame(mw(`ASQ_CODE_UPPER_INT, 4'hc));
		rd(`ASQ_REG_RESULTS, st);
		chk(st, 16'h0004);
		chk({7'h00, result_count}, 16'h0004);
		seen.delete();
		wr(`ASQ_REG_CTRL, 16'h0001);
		repeat (200) @(posedge ref_clk);
		exp = '{4'hc, 4'hd, 4'he, 4'hf};
		cmpq();
		chk({15'h0000, conv_int_clk}, 16'h0001);
		chk({15'h0000, conv_avg_allowed}, 16'h0001);
		chk({15'h0000, seq_busy}, 16'h0000);
		wr(`ASQ_REG_CUSTOM, 16'ha041);
		frame(mw(`ASQ_CODE_CUSTOM_INT, 4'hf));
		rd(`ASQ_REG_CUSTOM, st);
		chk(st, 16'ha041);
		chk({7'h00, result_count}, 16'h0004);
		seen.delete();
		wr(`ASQ_REG_CTRL, 16'h0001);
		repeat (200) @(posedge ref_clk);
		exp = '{4'h0, 4'h6, 4'hd, 4'hf};
		cmpq();
		// Standard scan paced by the internal clock, channels zero to N.
		frame(mw(`ASQ_CODE_STD_INT, 4'h2));
		seen.delete();
		wr(`ASQ_REG_CTRL, 16'h0001);
		repeat (200) @(posedge ref_clk);
		exp = '{4'h0, 4'h1, 4'h2};
		cmpq();
		wr(`ASQ_REG_CUSTOM, 16'hffff);
		frame(mw(`ASQ_CODE_CUSTOM_EXT, 4'h2));
		chk({7'h00, result_count}, 16'h0010);
		chk({15'h0000, conv_avg_allowed}, 16'h0000);
		runs(17);
		exp.delete();
		for (int i = 0; i < 17; i++) exp.push_back(4'(i));
		cmpq();
		wr(`ASQ_REG_SEQ_LEN, 16'h0004);
		wr(`ASQ_REG_SEQ_ADDR, 16'h0000);
		exp = '{4'h5, 4'h5, 4'h2, 4'h9, 4'h0, 4'h5};
		for (int i = 0; i < 5; i++) wr(`ASQ_REG_SEQ_DATA, {12'h000, exp[i]});
		frame(mw(`ASQ_CODE_SEQ_SET, 4'h7));
		seen.delete();
		wr(`ASQ_REG_CTRL, 16'h0001);
		repeat (60) @(posedge ref_clk);
		chk(16'(seen.size()), 16'h0000);
		chk({15'h0000, conv_avg_allowed}, 16'h0000);
		runs(6);
		cmpq();
		close_out();
	end
endmodule : test_adc_scan_mode_sequencer
`default_nettype wire
